//--- rtl/atten_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the step
  attenuator control block.
  Assumes a 32-bit AXI4-Lite register bus and a 20 MHz system clock.
*/
`ifndef ATTEN_CFG_SVH
`define ATTEN_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define ATT_OFS_CTRL    12'h000
`define ATT_OFS_STATUS  12'h004
`define ATT_OFS_WORD    12'h008
`define ATT_OFS_UPDCNT  12'h00C

// ****************************************
// Field positions
// ****************************************
`define ATT_CTRL_FREEZE_BIT   0
`define ATT_STAT_SERIAL_BIT   8
`define ATT_STAT_STROBE_BIT   9
`define ATT_STAT_FROZEN_BIT   10

// ****************************************
// Reset values and codes
// ****************************************
`define ATT_CODE_MAX     7'h7F
`define ATT_CODE_ZERO    7'h00
`define ATT_WORD_RST     8'h00
`define ATT_RESP_OKAY    2'h0
`define ATT_RESP_SLVERR  2'h2

// ****************************************
// Timing
// ****************************************
`define ATT_CLK_SYS_MHZ       20
`define ATT_STROBE_GAP_NS     10
`define ATT_STROBE_GAP_CYC    ((`ATT_STROBE_GAP_NS * `ATT_CLK_SYS_MHZ + 999) / 1000)
`define ATT_SETTLE_CYC        3'h5

`endif

//--- rtl/atten_pkg.sv
/*
  Types shared by the step attenuator control block.
  Assumes atten_cfg.svh for all numeric constants.
*/
package atten_pkg;

  typedef enum logic {
    MODE_PARALLEL,
    MODE_SERIAL
  } atten_mode_t;

  typedef struct packed {
    logic       strobe;
    logic       mode_sel;
    logic [6:0] par_code;
  } pin_bus_t;

  typedef struct packed {
    logic       frozen;
    logic       strobe;
    logic       serial;
    logic [6:0] code;
  } atten_status_t;

endpackage : atten_pkg

//--- rtl/pin_sync.sv
/*
  Three-stage synchroniser for asynchronous pins, one lane per bit.
  Assumes the output only moves once stages two and three agree.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ****************************************
  // Per-bit stages
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          s1_q[g]   <= 1'b0;
          s2_q[g]   <= 1'b0;
          s3_q[g]   <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          s1_q[g] <= i_async[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            o_sync[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

endmodule : pin_sync

//--- rtl/serial_shifter.sv
/*
  Serial input shift register running on the serial clock.
  Assumes the controller holds the clock still while the strobe is high.
*/
`timescale 1ns/1ps

module serial_shifter #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk_serial,
  input  wire logic             i_sdata,
  output logic      [WIDTH-1:0] o_word
);

  // ****************************************
  // Shift, first bit ends in bit 0
  // ****************************************
  always_ff @(posedge i_clk_serial) begin
    o_word <= {i_sdata, o_word[WIDTH-1:1]};
  end

endmodule : serial_shifter

//--- rtl/step_attenuator_control.sv
/*
  Control logic of a 7-bit digital step attenuator: serial port on its own
  clock, direct and strobe-latched parallel inputs, AXI4-Lite registers.
  Assumes all pins are asynchronous to i_clk_sys and that the serial clock
  stands still while the latch strobe is high.
*/
`timescale 1ns/1ps

`include "atten_cfg.svh"

module step_attenuator_control
  import atten_pkg::*;
#(
  parameter int CODE_W = 7,
  parameter int WORD_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  input  wire logic              i_clk_serial,
  input  wire logic              i_sdata,
  input  wire logic              i_latch_strobe,
  input  wire logic              i_mode_sel,
  input  wire logic [CODE_W-1:0] i_par_code,
  output logic      [CODE_W-1:0] o_atten_code,
  output logic                   o_serial_mode,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ****************************************
  // Declarations
  // ****************************************
  pin_bus_t          pins_raw;
  pin_bus_t          pins_s;
  logic [WORD_W-1:0] word_link;
  logic [WORD_W-1:0] word_s;
  logic              strobe_prev_q;
  logic [2:0]        settle_q;
  logic              strobe_rise;
  atten_mode_t       mode_q;
  logic [CODE_W-1:0] atten_q;
  logic [CODE_W-1:0] atten_d;
  logic [WORD_W-1:0] last_word_q;
  logic [15:0]       upd_cnt_q;
  logic              freeze_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic [11:0]       awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_fire;
  logic              aw_got_d;
  logic              w_got_d;
  logic              bvalid_d;
  logic              rvalid_d;
  logic [31:0]       rd_mux;
  logic              rd_ok;
  logic              wr_ok;
  atten_status_t     status;

  // ****************************************
  // Link side shift register
  // ****************************************
  serial_shifter #(
    .WIDTH (WORD_W)
  ) u_shifter (
    .i_clk_serial (i_clk_serial),
    .i_sdata      (i_sdata),
    .o_word       (word_link)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pins_raw = '{strobe: i_latch_strobe, mode_sel: i_mode_sel, par_code: i_par_code};

  pin_sync #(
    .WIDTH ($bits(pin_bus_t))
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (pins_raw),
    .o_sync    (pins_s)
  );

  // Word is quiet while the strobe is high, so it settles with the strobe
  pin_sync #(
    .WIDTH (WORD_W)
  ) u_word_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (word_link),
    .o_sync    (word_s)
  );

  // ****************************************
  // Strobe edge detect
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      strobe_prev_q <= 1'b0;
      settle_q      <= 3'h0;
    end else begin
      strobe_prev_q <= pins_s.strobe;
      if (settle_q != `ATT_SETTLE_CYC) begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  assign strobe_rise = pins_s.strobe && !strobe_prev_q && (settle_q == `ATT_SETTLE_CYC);

  // ****************************************
  // Mode select
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mode_q <= MODE_PARALLEL;
    end else if (pins_s.mode_sel) begin
      mode_q <= MODE_SERIAL;
    end else begin
      mode_q <= MODE_PARALLEL;
    end
  end

  // ****************************************
  // Attenuation source selection
  // ****************************************
  always_comb begin
    atten_d = atten_q;
    case (mode_q)
      MODE_SERIAL: begin
        if (strobe_rise) begin
          atten_d = word_s[CODE_W-1:0];
        end
      end
      MODE_PARALLEL: begin
        if (pins_s.strobe) begin
          atten_d = pins_s.par_code;
        end
      end
      default: begin
        atten_d = atten_q;
      end
    endcase
  end

  // ****************************************
  // Attenuation register
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      atten_q <= `ATT_CODE_MAX;
    end else if (!freeze_q && settle_q == `ATT_SETTLE_CYC) begin
      atten_q <= atten_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_atten_code  <= `ATT_CODE_MAX;
      o_serial_mode <= 1'b0;
    end else begin
      o_atten_code  <= atten_q;
      o_serial_mode <= (mode_q == MODE_SERIAL);
    end
  end

  // ****************************************
  // Last latched serial word and update count
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      last_word_q <= `ATT_WORD_RST;
    end else if (mode_q == MODE_SERIAL && strobe_rise) begin
      last_word_q <= word_s;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      upd_cnt_q <= 16'h0000;
    end else if (!freeze_q && settle_q == `ATT_SETTLE_CYC && atten_d != atten_q) begin
      upd_cnt_q <= upd_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    bvalid_d = s_axi_bvalid;
    if (aw_hs) begin
      aw_got_d = 1'b1;
    end
    if (w_hs) begin
      w_got_d = 1'b1;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_got_q      <= aw_got_d;
      w_got_q       <= w_got_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_awready <= !aw_got_d && !bvalid_d && !wr_fire;
      s_axi_wready  <= !w_got_d && !bvalid_d && !wr_fire;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_comb begin
    case (awaddr_q)
      `ATT_OFS_CTRL,
      `ATT_OFS_STATUS,
      `ATT_OFS_WORD,
      `ATT_OFS_UPDCNT: wr_ok = 1'b1;
      default:         wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s_axi_bresp <= `ATT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_ok ? `ATT_RESP_OKAY : `ATT_RESP_SLVERR;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      freeze_q <= 1'b0;
    end else if (wr_fire && awaddr_q == `ATT_OFS_CTRL && wstrb_q[0]) begin
      freeze_q <= wdata_q[`ATT_CTRL_FREEZE_BIT];
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign status = '{frozen: freeze_q, strobe: pins_s.strobe,
                    serial: (mode_q == MODE_SERIAL), code: atten_q};

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `ATT_OFS_CTRL: begin
        rd_mux[`ATT_CTRL_FREEZE_BIT] = freeze_q;
      end
      `ATT_OFS_STATUS: begin
        rd_mux[CODE_W-1:0]           = status.code;
        rd_mux[`ATT_STAT_SERIAL_BIT] = status.serial;
        rd_mux[`ATT_STAT_STROBE_BIT] = status.strobe;
        rd_mux[`ATT_STAT_FROZEN_BIT] = status.frozen;
      end
      `ATT_OFS_WORD: begin
        rd_mux[WORD_W-1:0] = last_word_q;
      end
      `ATT_OFS_UPDCNT: begin
        rd_mux[15:0] = upd_cnt_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    rvalid_d = s_axi_rvalid;
    if (ar_hs) begin
      rvalid_d = 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ATT_RESP_OKAY;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= !rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `ATT_RESP_OKAY : `ATT_RESP_SLVERR;
      end
    end
  end

endmodule : step_attenuator_control

//--- sim/atten_ctl_model.sv
/*
  Controller model that drives the attenuator control pins.
  Assumes callers start each task just after a system clock edge.
*/
`timescale 1ns/1ps

module atten_ctl_model (
  output logic       o_sclk,
  output logic       o_sdata,
  output logic       o_strobe,
  output logic       o_mode,
  output logic [6:0] o_code
);
  // ****************************************
  // Pin driving
  // ****************************************
  initial begin
    o_sclk   = 1'b0;
    o_sdata  = 1'b0;
    o_strobe = 1'b0;
    o_mode   = 1'b0;
    o_code   = 7'h00;
  end

  task automatic pins(input logic m, input logic s, input logic [6:0] c);
    o_mode   <= m;
    o_strobe <= s;
    o_code   <= c;
  endtask : pins

  task automatic shift(input logic [7:0] w, input logic frame, input int slow);
    #10;
    if (frame) begin
      o_strobe = 1'b0;
      o_code   = 7'h00;
      #200;
    end
    for (int i = 0; i < 8; i++) begin
      o_sdata = w[i];
      #(15 + slow);
      o_sclk = 1'b1;
      #15;
      o_sclk = 1'b0;
    end
    o_sdata = 1'b0;
    #20;
    if (frame) begin
      o_strobe = 1'b1;
      #400;
    end
  endtask : shift
endmodule : atten_ctl_model

//--- sim/atten_ctl_chk.sv
/*
  Assertions on the attenuator control top ports.
  Assumes binding into the top module, pins driven as the contract allows.
*/
`timescale 1ns/1ps

module atten_ctl_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic        i_clk_serial,
  input wire logic        i_sdata,
  input wire logic        i_latch_strobe,
  input wire logic        i_mode_sel,
  input wire logic [6:0]  i_par_code,
  input wire logic [6:0]  o_atten_code,
  input wire logic        o_serial_mode,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  // ****************************************
  // Reference shifter and properties
  // ****************************************
  logic [7:0] sh_q;
  always_ff @(posedge i_clk_serial) sh_q <= {i_sdata, sh_q[7:1]};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  reset_max_a: assert property (disable iff (1'b0) i_srst |=> o_atten_code == 7'h7F && !o_serial_mode)
    else $error("attenuation not maximum after reset");
  mode_ser_a: assert property (i_mode_sel [*8] |-> o_serial_mode)
    else $error("serial mode not entered");
  mode_par_a: assert property (!i_mode_sel [*8] |-> !o_serial_mode)
    else $error("parallel mode not entered");
  par_hold_a: assert property ((!i_mode_sel && !i_latch_strobe) [*8] |=> $stable(o_atten_code))
    else $error("code moved with strobe low");
  par_track_a: assert property ((!i_mode_sel && i_latch_strobe && $stable(i_par_code)) [*8]
    |-> o_atten_code == i_par_code)
    else $error("code not tracking parallel inputs");
  ser_hold_a: assert property ((i_mode_sel && !i_latch_strobe) [*8] |=> $stable(o_atten_code))
    else $error("serial code moved without strobe");
  ser_load_a: assert property ($rose(i_latch_strobe) && i_mode_sel |-> ##8 o_atten_code == sh_q[6:0])
    else $error("serial word not loaded");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  rd_slverr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h00C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  cover property ($rose(i_latch_strobe) && i_mode_sel);
  cover property (!i_mode_sel && i_latch_strobe && $changed(i_par_code));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : atten_ctl_chk

//--- sim/tb_top.sv
/*
  Self-checking bench of the step attenuator control block.
  Assumes the controller model drives the pins and reads go over AXI4-Lite.
*/
`timescale 1ns/1ps

module tb_top;
  // ****************************************
  // Signals, instances, helpers
  // ****************************************
  logic        i_clk_sys, i_srst, sclk, sdata, strobe, mode;
  logic [6:0]  code, c;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] q[$];
  logic [7:0]  w;
  logic [6:0]  atten;
  logic        smode;
  logic [33:0] x;
  int          errors, comparisons;

  step_attenuator_control step_attenuator_control_inst (
    .i_clk_sys, .i_srst, .i_clk_serial(sclk), .i_sdata(sdata), .i_latch_strobe(strobe),
    .i_mode_sel(mode), .i_par_code(code), .o_atten_code(atten), .o_serial_mode(smode),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  atten_ctl_model ctl (.o_sclk(sclk), .o_sdata(sdata), .o_strobe(strobe), .o_mode(mode), .o_code(code));

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic tmo(input int n);
    if (n >= 100) begin
      errors++;
      wrap_up();
    end
  endtask : tmo

  function automatic logic [33:0] st(input logic [2:0] f, input logic [6:0] v);
    return {23'h0, f, 1'b0, v};
  endfunction : st

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    q.push_back({r, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    s_axi_bready <= 1'b0;
    @(posedge i_clk_sys);
    tmo(n);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n;
    n = 0;
    q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    s_axi_rready <= 1'b0;
    @(posedge i_clk_sys);
    tmo(n);
  endtask : rd

  task automatic pset(input logic m, input logic s, input logic [6:0] v);
    @(posedge i_clk_sys);
    ctl.pins(m, s, v);
    repeat (10) @(posedge i_clk_sys);
  endtask : pset

  always @(posedge i_clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      x = q.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, x);
      if (s_axi_araddr == 12'h004)
        chk({26'h0, smode, atten}, {26'h0, x[8], x[6:0]});
    end
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, q.pop_front());
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(13141));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    errors = 0;
    comparisons = 0;
    i_srst = 1'b1;
    ctl.pins(1'b0, 1'b0, 7'($urandom));
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(posedge i_clk_sys);
    rd(12'h000, 34'h0);
    rd(12'h004, st(3'b000, 7'h7F));
    rd(12'h008, 34'h0);
    rd(12'h00C, 34'h0);
    rd(12'h010, {2'h2, 32'h0});
    wr(12'h010, 32'h1, 2'h2);
    wr(12'h000, 32'h1, 2'h0);
    rd(12'h004, st(3'b100, 7'h7F));
    wr(12'h000, 32'h0, 2'h0);
    wr(12'h004, 32'hFFFF, 2'h0);
    for (int i = 0; i < 8; i++) begin
      c = i == 0 ? 7'h00 : i == 1 ? 7'h7F : 7'($urandom);
      pset(1'b0, 1'b1, c);
      rd(12'h004, st(3'b010, c));
    end
    ctl.shift(8'($urandom), 1'b0, 0);
    @(posedge i_clk_sys);
    rd(12'h004, st(3'b010, c));
    pset(1'b0, 1'b0, c);
    pset(1'b0, 1'b0, ~c);
    rd(12'h004, st(3'b000, c));
    pset(1'b0, 1'b1, ~c);
    rd(12'h004, st(3'b010, ~c));
    pset(1'b1, 1'b0, 7'h00);
    for (int i = 0; i < 5; i++) begin
      w = i == 0 ? 8'h80 : i == 1 ? 8'hFF : 8'($urandom);
      ctl.shift(w, 1'b1, 20 * (i % 2));
      repeat (4) @(posedge i_clk_sys);
      rd(12'h004, st(3'b011, w[6:0]));
      rd(12'h008, {26'h0, w});
    end
    i_srst <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    rd(12'h004, st(3'b011, 7'h7F));
    rd(12'h008, 34'h0);
    rd(12'h00C, 34'h0);
    pset(1'b0, 1'b1, 7'h55);
    rd(12'h004, st(3'b010, 7'h55));
    wrap_up();
  end
endmodule : tb_top

bind step_attenuator_control atten_ctl_chk atten_ctl_chk_inst (
  .i_clk_sys, .i_srst, .i_clk_serial, .i_sdata, .i_latch_strobe, .i_mode_sel, .i_par_code,
  .o_atten_code, .o_serial_mode, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid);
